// ===== logic/pss_consts.vh
// Constants for the strap sampler block
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
// Register byte offsets
`define PSS_OFF_CTRL 8'h00
`define PSS_OFF_STRAP 8'h04
`define PSS_OFF_ADVERT 8'h08
`define PSS_OFF_ADDR 8'h0C
// Status register fields
`define PSS_ST_ADDR_LSB 0
`define PSS_ST_ADDR_MSB 4
`define PSS_ST_ADV_BIT 5
`define PSS_ST_RMII_BIT 6
`define PSS_ST_ISO_BIT 7
// Control register fields
`define PSS_CTRL_ISO_CLR_BIT 0
// Advertisement ability fields
`define PSS_ADV_10HD_BIT 0
`define PSS_ADV_10FD_BIT 1
`define PSS_ADV_100HD_BIT 2
`define PSS_ADV_100FD_BIT 3
// Pull defaults of the strap pins
`define PSS_PULL_ADDR0 1'h1
`define PSS_PULL_ADDR_UPPER 4'h0
`define PSS_PULL_ADVERT 1'h1
`define PSS_PULL_IFSEL 1'h0
// Bus responses
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2
`endif

// ===== logic/pss_strap_sampler.v
// Strap sampler: latches strap levels during reset, exposes them over AXI4-Lite
`timescale 1ns/1ps
`include "pss_consts.vh"

// ****************************************
// Operating notes
// ****************************************
// Straps are sampled on every edge while aresetn is low, whatever clk_en says.
// The value sampled at the last reset edge is the one that sticks.
// Sampling ignores clk_en on purpose: a frozen clock enable must not lose a strap.
// The strap inputs are already resolved levels; pulls live outside this block.
// While reset is held every shared pin is released, so the pulls set the level.
// The first enabled edge after release loads all configuration outputs at once.
// From then on the configuration only moves on a software write or a new reset.
// Isolation can only come from a strapped zero address, never from software.
// Software may clear isolation through the control register, never set it.
// Bus answers: readys one cycle after valid, response one cycle after both halves.
// Limitation: strap levels must be stable for at least the last reset edge.
// Limitation: the address width parameter assumes five strap pins.
// Trade-off: pins are registered, costing one cycle before they drive after reset.

module pss_strap_sampler #(
	parameter ADDR_W = 5
) (
	// Clock, enable and reset
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	// Strap pin inputs, already resolved from external or internal pulls
	input wire mgmt_addr_strap_bit0,
	input wire [3:0] mgmt_addr_strap_upper,
	input wire advertise_select_strap,
	input wire ifsel_strap,
	// Strap pin output enables and functional drive
	input wire [ADDR_W-1:0] func_addr_pins,
	input wire func_link_indicator,
	input wire func_ifsel_pin,
	output reg [ADDR_W-1:0] addr_pins_out,
	output reg [ADDR_W-1:0] addr_pins_oe,
	output reg link_indicator_pin_out,
	output reg link_indicator_pin_oe,
	output reg ifsel_pin_out,
	output reg ifsel_pin_oe,
	// Configuration results
	output reg [ADDR_W-1:0] phy_control_reg,
	output reg mii_isolate,
	output reg rmii_select,
	output reg [3:0] advert_abilities,
	output reg mode_ctrl_advert,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ****************************************
	// Strap latches
	// ****************************************
	reg [ADDR_W-1:0] strap_addr;
	reg strap_adv;
	reg strap_ifsel;
	reg [3:0] next_adv;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg aw_held;
	reg w_held;
	reg [31:0] next_rdata;
	reg next_rerr;
	wire do_write;

	// Abilities from the advertise strap; half duplex always present
	always @* begin
		next_adv = 4'h0;
		next_adv[`PSS_ADV_10HD_BIT] = 1'b1;
		next_adv[`PSS_ADV_100HD_BIT] = 1'b1;
		next_adv[`PSS_ADV_10FD_BIT] = strap_adv;
		next_adv[`PSS_ADV_100FD_BIT] = strap_adv;
	end

	// Sample continuously while reset is low, so the last level before release sticks.
	// Pull defaults are resolved outside; they only show through these pins.
	always @(posedge aclk) begin
		if (!aresetn) begin
			strap_addr <= {mgmt_addr_strap_upper, mgmt_addr_strap_bit0};
			strap_adv <= advertise_select_strap;
			strap_ifsel <= ifsel_strap;
		end
	end

	// Load flag: set once after reset, holds the latched values stable
	reg loaded;
	always @(posedge aclk) begin
		if (!aresetn) begin
			loaded <= 1'b0;
		end else if (clk_en) begin
			loaded <= 1'b1;
		end
	end

	// ****************************************
	// Write decode
	// ****************************************
	// A write lands only once both halves are held and no response is pending
	wire wr_to_addr;
	wire wr_to_ctrl;
	wire iso_clear_req;
	assign wr_to_addr = do_write && (aw_addr == `PSS_OFF_ADDR) && w_strb[0];
	assign wr_to_ctrl = do_write && (aw_addr == `PSS_OFF_CTRL) && w_strb[0];
	// Clearing isolation is a software escape; it can never set it
	assign iso_clear_req = wr_to_ctrl && w_data[`PSS_CTRL_ISO_CLR_BIT];

	// ****************************************
	// Configuration registers
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			phy_control_reg <= {ADDR_W{1'b0}};
			mii_isolate <= 1'b0;
			rmii_select <= 1'b0;
			advert_abilities <= 4'h0;
			mode_ctrl_advert <= 1'b0;
		end else if (clk_en) begin
			if (wr_to_addr) begin
				// Software address change never touches isolation
				phy_control_reg <= w_data[ADDR_W-1:0];
			end else if (!loaded) begin
				phy_control_reg <= strap_addr;
			end
			if (!loaded) begin
				// First enabled cycle after release loads the strap results
				mii_isolate <= (strap_addr == {ADDR_W{1'b0}});
				rmii_select <= strap_ifsel;
				advert_abilities <= next_adv;
				mode_ctrl_advert <= strap_adv;
			end else if (iso_clear_req) begin
				mii_isolate <= 1'b0;
			end
		end
	end

	// ****************************************
	// Shared pin drive
	// ****************************************
	// Address pins, one flop pair per bit; released in reset so pulls win
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_W; gi = gi + 1) begin : g_addr_pin
			always @(posedge aclk) begin
				if (!aresetn) begin
					addr_pins_out[gi] <= 1'b0;
					addr_pins_oe[gi] <= 1'b0;
				end else if (clk_en) begin
					addr_pins_out[gi] <= func_addr_pins[gi];
					addr_pins_oe[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// Link and interface pins float during reset so pulls set the level
	always @(posedge aclk) begin
		if (!aresetn) begin
			link_indicator_pin_out <= 1'b0;
			link_indicator_pin_oe <= 1'b0;
			ifsel_pin_out <= 1'b0;
			ifsel_pin_oe <= 1'b0;
		end else if (clk_en) begin
			link_indicator_pin_out <= func_link_indicator;
			link_indicator_pin_oe <= 1'b1;
			ifsel_pin_out <= func_ifsel_pin;
			ifsel_pin_oe <= 1'b1;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Write channels are captured independently, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PSS_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `PSS_OFF_CTRL || aw_addr == `PSS_OFF_ADDR)
					? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Read mux; unmapped offsets answer SLVERR with zero data
	always @* begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		case (s_axi_araddr)
			`PSS_OFF_CTRL: next_rdata[0] = mii_isolate;
			`PSS_OFF_STRAP: begin
				next_rdata[`PSS_ST_ADDR_MSB:`PSS_ST_ADDR_LSB] = strap_addr;
				next_rdata[`PSS_ST_ADV_BIT] = strap_adv;
				next_rdata[`PSS_ST_RMII_BIT] = strap_ifsel;
				next_rdata[`PSS_ST_ISO_BIT] = mii_isolate;
			end
			`PSS_OFF_ADVERT: next_rdata[3:0] = advert_abilities;
			`PSS_OFF_ADDR: next_rdata[ADDR_W-1:0] = phy_control_reg;
			default: next_rerr = 1'b1;
		endcase
	end

	// One read at a time; arready pulses for one cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PSS_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rerr ? `PSS_RESP_SLVERR : `PSS_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ===== testbench/pss_pulls.sv
// Board pull model for the shared strap pins
`timescale 1ns/1ps
// ***
// Strap pin resolution
// ***
module pss_pulls (
	// Device drive
	input wire [6:0] oe,
	input wire [6:0] dout,
	// Board resistors
	input wire [6:0] en,
	input wire [6:0] val,
	// Resolved pin levels
	output wire [6:0] lvl
);
	// Weak pulls: address bit 0 and advertise up, the rest down
	localparam [6:0] PULLS = 7'h21;
	// Device drive wins over resistors, resistors over weak pulls
	assign lvl = (oe & dout) | (~oe & en & val) | (~oe & ~en & PULLS);
endmodule

// ===== testbench/pss_strap_sampler_assertions.sv
// Assertion checker for the strap sampler
`timescale 1ns/1ps
// ***
// Strap checks
// ***
module pss_chk #(parameter ADDR_W = 5) (
	// Clock and strap levels
	input wire aclk, aresetn, clk_en,
	input wire mgmt_addr_strap_bit0, advertise_select_strap, ifsel_strap,
	input wire [3:0] mgmt_addr_strap_upper,
	// Pin enables and latched results
	input wire [ADDR_W-1:0] addr_pins_oe, phy_control_reg,
	input wire link_indicator_pin_oe, ifsel_pin_oe,
	input wire mii_isolate, rmii_select, mode_ctrl_advert,
	input wire [3:0] advert_abilities
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Address as seen on the pins
	wire [4:0] pin_addr = {mgmt_addr_strap_upper, mgmt_addr_strap_bit0};
	// Last reset edge wins; results show one edge after release
	pins_driven_a: assert property (
		$rose(aresetn) && clk_en |=> &{addr_pins_oe, link_indicator_pin_oe, ifsel_pin_oe})
		else $error("pins idle");
	addr_latch_a: assert property (
		$rose(aresetn) |=> phy_control_reg == $past(pin_addr, 2)) else $error("bad addr");
	iso_strap_a: assert property (
		$rose(aresetn) |=> mii_isolate == (phy_control_reg == 5'h00)) else $error("bad iso");
	mode_latch_a: assert property (
		$rose(aresetn) |=> mode_ctrl_advert == $past(advertise_select_strap, 2))
		else $error("bad mode");
	ifsel_latch_a: assert property (
		$rose(aresetn) |=> rmii_select == $past(ifsel_strap, 2)) else $error("bad ifsel");
	// Half duplex always offered, full duplex only with the strap high
	advert_map_a: assert property (
		$past(aresetn) |-> advert_abilities == {mode_ctrl_advert, 1'h1, mode_ctrl_advert, 1'h1})
		else $error("bad abilities");
	// Only a reset may move the latch or raise isolate
	cfg_hold_a: assert property (
		$changed({rmii_select, mode_ctrl_advert, advert_abilities}) |-> !$past(aresetn, 2))
		else $error("config moved");
	iso_no_rise_a: assert property (
		$rose(mii_isolate) |-> !$past(aresetn, 2)) else $error("iso rose");
	cover property ($rose(aresetn));
	cover property (mii_isolate);
	cover property (rmii_select);
endmodule

bind pss_strap_sampler pss_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== testbench/phy_strap_sampler_tb.sv
// Self-checking bench for the strap sampler
`timescale 1ns/1ps
`include "pss_consts.vh"
// ***
// Bench top
// ***
module phy_strap_sampler_tb;
	reg aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
	reg [4:0] func_addr_pins = 5'h0A;
	reg func_link_indicator = 1'h1, func_ifsel_pin = 1'h0;
	reg [6:0] ext_en = 7'h00, ext_val = 7'h00;
	reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire [4:0] addr_pins_out, addr_pins_oe, phy_control_reg;
	wire link_indicator_pin_out, link_indicator_pin_oe, ifsel_pin_out, ifsel_pin_oe;
	wire mii_isolate, rmii_select, mode_ctrl_advert, s_axi_awready, s_axi_wready;
	wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [3:0] advert_abilities;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [6:0] lvl;
	wire mgmt_addr_strap_bit0 = lvl[0], advertise_select_strap = lvl[5], ifsel_strap = lvl[6];
	wire [3:0] mgmt_addr_strap_upper = lvl[4:1];
	integer num_errors = 0, n_checks = 0, cyc = 0, i;
	reg [1:0] resp;
	reg [31:0] rd;
	reg [21:0] rows [0:4];
	pss_strap_sampler i_dut (.*);
	pss_pulls i_pulls (.oe({ifsel_pin_oe, link_indicator_pin_oe, addr_pins_oe}),
		.dout({ifsel_pin_out, link_indicator_pin_out, addr_pins_out}),
		.en(ext_en), .val(ext_val), .lvl(lvl));
	initial forever #12.5 aclk = ~aclk;
	// Watchdog: the run needs about 120 cycles
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			num_errors = num_errors + 1;
			give_verdict;
		end
	end
	task chk(input [31:0] got, input [31:0] want);
		n_checks = n_checks + 1;
		if (got !== want) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task give_verdict;
		if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task rst;
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
	endtask
	// One bus transfer; a read when wr is low
	task xfer(input wr, input [7:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_bvalid | s_axi_rvalid) break;
		end
		resp = wr ? s_axi_bresp : s_axi_rresp;
		rd = s_axi_rdata;
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
	endtask
	// Rows: resistor enables, resistor levels, expected status byte
	initial begin
		rows[0] = {7'h00, 7'h00, 8'h21};
		rows[1] = {7'h7F, 7'h00, 8'h80};
		rows[2] = {7'h01, 7'h00, 8'hA0};
		rows[3] = {7'h7F, 7'h56, 8'h56};
		rows[4] = {7'h7F, 7'h7F, 8'h7F};
		for (i = 0; i < 5; i = i + 1) begin
			ext_en <= rows[i][21:15];
			ext_val <= rows[i][14:8];
			rst;
			xfer(1'h0, `PSS_OFF_STRAP, 32'h0);
			chk(rd, rows[i][7:0]);
			chk(phy_control_reg, rows[i][4:0]);
			chk(mii_isolate, rows[i][7]);
			chk(rmii_select, rows[i][6]);
			chk(mode_ctrl_advert, rows[i][5]);
			chk(advert_abilities, {2{rows[i][5], 1'h1}});
		end
		// Pins now carry functional values; the latch must not follow
		func_addr_pins <= 5'h15;
		xfer(1'h1, `PSS_OFF_ADDR, 32'h0);
		chk(addr_pins_out, 5'h15);
		chk(rmii_select, 1'h1);
		chk(mii_isolate, 1'h0);
		xfer(1'h0, `PSS_OFF_ADDR, 32'h0);
		chk(rd, 32'h0);
		// Read-only and unmapped places refuse
		xfer(1'h1, `PSS_OFF_STRAP, 32'hFF);
		chk(resp, `PSS_RESP_SLVERR);
		xfer(1'h0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(resp, `PSS_RESP_SLVERR);
		// Functional drive on the link and interface pins
		chk(link_indicator_pin_out, 1'h1);
		chk({ifsel_pin_oe, link_indicator_pin_oe, addr_pins_oe}, 7'h7F);
		chk(ifsel_pin_out, 1'h0);
		xfer(1'h0, `PSS_OFF_ADVERT, 32'h0);
		chk(rd, 32'h0000000F);
		// Strapped isolate, then the software escape clears it
		ext_val <= 7'h00;
		rst;
		chk(mii_isolate, 1'h1);
		xfer(1'h1, `PSS_OFF_CTRL, 32'h1);
		chk(resp, `PSS_RESP_OKAY);
		xfer(1'h0, `PSS_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(phy_control_reg, 5'h00);
		// Enable low freezes the pin drive
		clk_en <= 1'h0;
		func_link_indicator <= 1'h0;
		repeat (3) @(posedge aclk);
		chk(link_indicator_pin_out, 1'h1);
		clk_en <= 1'h1;
		repeat (2) @(posedge aclk);
		chk(link_indicator_pin_out, 1'h0);
		give_verdict;
	end
endmodule
